// ---- logic/sdt_shadow_transfer_regs.sv ----
`include "sdt_params.svh"
module sdt_shadow_transfer_regs #(
  parameter int COEF_W = 64,
  // The vendor code default is an arbitrary neutral value.
  parameter logic [15:0] VENDOR_CODE = 16'ha5c3
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [`SDT_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic phase_update_mode_in,
  input wire sdt_pkg::sdt_phase_t phase_staged_in,
  input wire logic [COEF_W-1:0] coef_staged_in,
  input wire logic [1:0] pin_function_in,
  input wire logic [1:0] chan_power_mode_in,
  input wire logic power_down_standby_pin_in,
  output sdt_pkg::sdt_phase_t phase_active_out,
  output logic [COEF_W-1:0] coef_active_out,
  output sdt_pkg::sdt_power_t power_out,
  output logic [1:0] chan_power_mode_out
);

  // ==========================================================
  // Register decode
  localparam logic [7:0] XFER_RESET = `SDT_XFER_RESET;
  localparam logic [7:0] LOCAL_RESET = `SDT_LOCAL_RESET;
  sdt_pkg::sdt_state_t state;
  logic xfer_bit;
  logic local_dis;
  logic xfer_wr;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_level;
  logic next_pd;
  logic next_sb;

  assign xfer_wr = reg_wr_en_in && (reg_addr_in == `SDT_OFF_XFER);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (reg_rd_en_in)
    begin
      case (reg_addr_in)
        `SDT_OFF_VENDOR_LOW: reg_rdata_out <= VENDOR_CODE[7:0];
        `SDT_OFF_VENDOR_HIGH: reg_rdata_out <= VENDOR_CODE[15:8];
        `SDT_OFF_XFER: reg_rdata_out <= {7'h00, xfer_bit};
        `SDT_OFF_LOCAL_PIN: reg_rdata_out <= {local_dis, 7'h00};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      local_dis <= LOCAL_RESET[`SDT_LOCAL_DIS_BIT];
    end
    else if (reg_wr_en_in && (reg_addr_in == `SDT_OFF_LOCAL_PIN))
    begin
      local_dis <= reg_wdata_in[`SDT_LOCAL_DIS_BIT];
    end
  end

  // ==========================================================
  // Transfer sequence
  // A write arriving while a transfer runs is dropped; the bit already reads one.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= sdt_pkg::SDT_IDLE;
      xfer_bit <= XFER_RESET[`SDT_XFER_BIT];
    end
    else
    begin
      case (state)
        sdt_pkg::SDT_IDLE:
        begin
          if (xfer_wr && reg_wdata_in[`SDT_XFER_BIT])
          begin
            state <= sdt_pkg::SDT_LOAD;
            xfer_bit <= 1'b1;
          end
        end
        sdt_pkg::SDT_LOAD:
        begin
          state <= sdt_pkg::SDT_DONE;
        end
        sdt_pkg::SDT_DONE:
        begin
          state <= sdt_pkg::SDT_IDLE;
          xfer_bit <= 1'b0;
        end
        default:
        begin
          state <= sdt_pkg::SDT_IDLE;
          xfer_bit <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      phase_active_out <= '0;
    end
    else if ((state == sdt_pkg::SDT_LOAD) || !phase_update_mode_in)
    begin
      phase_active_out <= phase_staged_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      coef_active_out <= '0;
    end
    else if (state == sdt_pkg::SDT_LOAD)
    begin
      coef_active_out <= coef_staged_in;
    end
  end

  // ==========================================================
  // Power pin
  // The pin is asynchronous, so a level counts only once two late stages agree.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
    end
    else
    begin
      pin_s1 <= power_down_standby_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
      begin
        pin_level <= pin_s3;
      end
    end
  end

  always_comb
  begin
    next_pd = 1'b0;
    next_sb = 1'b0;
    if (pin_level && !local_dis)
    begin
      case (pin_function_in)
        `SDT_FUNC_POWER_DOWN: next_pd = 1'b1;
        `SDT_FUNC_STANDBY: next_sb = 1'b1;
        default: next_pd = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      power_out <= '0;
      chan_power_mode_out <= 2'h0;
    end
    else
    begin
      power_out.power_down <= next_pd;
      power_out.standby <= next_sb;
      chan_power_mode_out <= (next_pd || next_sb) ? 2'h0 : chan_power_mode_in;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_xfer_start;
    state == sdt_pkg::SDT_IDLE && xfer_wr && reg_wdata_in[`SDT_XFER_BIT];
  endsequence

  sequence s_xfer_run;
    xfer_bit [*2] ##1 !xfer_bit;
  endsequence

  property p_self_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in) s_xfer_start |=> s_xfer_run;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("Transfer bit timing wrong.");

  property p_copy;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      s_xfer_start ##1 (state == sdt_pkg::SDT_LOAD) |=> coef_active_out == $past(coef_staged_in);
  endproperty
  a_copy: assert property (p_copy) else $error("Coefficients not loaded on transfer.");

  property p_phase_hold;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (phase_update_mode_in && state != sdt_pkg::SDT_LOAD) |=> $stable(phase_active_out);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("Phase changed without transfer.");

  property p_zero_write;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (state == sdt_pkg::SDT_IDLE && xfer_wr && !reg_wdata_in[`SDT_XFER_BIT]) |=> !xfer_bit;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("Zero write started a transfer.");

  property p_reserved;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_rd_en_in && reg_addr_in == `SDT_OFF_XFER) |=> reg_rdata_out[7:1] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved transfer bits nonzero.");

  property p_local_dis;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      local_dis |=> !power_out.power_down && !power_out.standby;
  endproperty
  a_local_dis: assert property (p_local_dis) else $error("Pin acted while disabled.");

  property p_func;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pin_level && !local_dis) |=>
        power_out.power_down == ($past(pin_function_in) == `SDT_FUNC_POWER_DOWN) &&
        power_out.standby == ($past(pin_function_in) == `SDT_FUNC_STANDBY);
  endproperty
  a_func: assert property (p_func) else $error("Pin function decode wrong.");

  property p_prio;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (power_out.power_down || power_out.standby) |-> chan_power_mode_out == 2'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("Channel mode not overridden.");

  property p_vendor;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_rd_en_in && reg_addr_in == `SDT_OFF_VENDOR_HIGH) |=> reg_rdata_out == VENDOR_CODE[15:8];
  endproperty
  a_vendor: assert property (p_vendor) else $error("Vendor high byte wrong.");

endmodule : sdt_shadow_transfer_regs

// ---- logic/sdt_params.svh ----
// Summary of operation
// - Writing one to transfer bit copies all staged values to active registers together.
// - With phase-update mode set, phase increment and offset change only on transfer.
// - Transfer also loads newly written filter coefficients into the active filter.
// - Transfer bit self-clears, staying one until the copy has completed.
// - Writing zero to transfer bit does nothing; bits 7 to 1 read zero.
// - Local disable bit zero keeps the power pin live; one ignores it fully.
// - With local disable zero, pin effect follows the global pin-function field.
// - Field 00 means full power-down, 01 means standby, 10 means pin ignored.
// - An asserted power pin overrides the per-channel power mode bits only when it acts: field 00 or 01 with local disable zero.
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH
// ==========================================================
// Register offsets
`define SDT_ADDR_W 15
`define SDT_OFF_VENDOR_LOW 15'h000c
`define SDT_OFF_VENDOR_HIGH 15'h000d
`define SDT_OFF_XFER 15'h000f
`define SDT_OFF_LOCAL_PIN 15'h003f
// ==========================================================
// Field positions and reset values
`define SDT_XFER_BIT 0
`define SDT_LOCAL_DIS_BIT 7
`define SDT_XFER_RESET 8'h00
`define SDT_LOCAL_RESET 8'h00
`define SDT_FUNC_POWER_DOWN 2'h0
`define SDT_FUNC_STANDBY 2'h1
`define SDT_FUNC_IGNORED 2'h2
// ==========================================================
// Datapath widths
`define SDT_PHASE_W 48
`endif

// ---- logic/sdt_pkg.sv ----
`include "sdt_params.svh"
package sdt_pkg;
  typedef enum logic [1:0] {
    SDT_IDLE,
    SDT_LOAD,
    SDT_DONE
  } sdt_state_t;

  typedef struct packed {
    logic [`SDT_PHASE_W-1:0] increment;
    logic [`SDT_PHASE_W-1:0] offset;
  } sdt_phase_t;

  typedef struct packed {
    logic power_down;
    logic standby;
  } sdt_power_t;
endpackage : sdt_pkg

// ---- verif/sdt_shadow_transfer_regs_tb_top.sv ----
`include "sdt_params.svh"
module sdt_shadow_transfer_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary vendor code, chosen only to differ from the default.
  localparam logic [15:0] VEND = 16'h3c5a;
  logic clk_sys_in, sys_rst_in, wr, rd, mode, pin;
  logic [`SDT_ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  sdt_pkg::sdt_phase_t stg, act;
  sdt_pkg::sdt_power_t pwr;
  logic [63:0] cst, cact;
  logic [1:0] func, cm, cmo, pw;
  int miscompares, n_compared;

  sdt_shadow_transfer_regs #(.COEF_W(64), .VENDOR_CODE(VEND)) dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_wr_en_in(wr), .reg_rd_en_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .phase_update_mode_in(mode),
    .phase_staged_in(stg), .coef_staged_in(cst), .pin_function_in(func), .chan_power_mode_in(cm),
    .power_down_standby_pin_in(pin), .phase_active_out(act), .coef_active_out(cact),
    .power_out(pwr), .chan_power_mode_out(cmo));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // Access tasks.
  task chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  // Each access waits an edge first, so a strobe is never lowered and raised in one step.
  task wr8(input logic [`SDT_ADDR_W-1:0] a, input logic [7:0] d);
    cyc(1);
    wr = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    wr = 1'b0;
  endtask : wr8

  task rd8(input logic [`SDT_ADDR_W-1:0] a, input logic [7:0] exp);
    cyc(1);
    rd = 1'b1;
    addr = a;
    cyc(1);
    rd = 1'b0;
    chk("rdata", {88'h0, exp}, {88'h0, rdata});
  endtask : rd8

  task end_of_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Main sequence.
  initial
  begin
    {wr, rd, mode, pin, addr, wdata, func, cm} = '0;
    stg = '0;
    cst = '0;
    miscompares = 0;
    n_compared = 0;
    sys_rst_in = 1'b1;
    cyc(2);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      rd8(`SDT_OFF_VENDOR_LOW, VEND[7:0]);
      rd8(`SDT_OFF_VENDOR_HIGH, VEND[15:8]);
      wr8(`SDT_OFF_VENDOR_LOW, ~VEND[7:0]);
      wr8(`SDT_OFF_VENDOR_HIGH, ~VEND[15:8]);
    end
    rd8(`SDT_OFF_XFER, `SDT_XFER_RESET);
    rd8(`SDT_OFF_LOCAL_PIN, `SDT_LOCAL_RESET);
    rd8(15'h0010, 8'h00);
    // Staged values must stay hidden while the update mode holds them back.
    mode = 1'b1;
    stg = {48'h0123456789ab, 48'hba9876543210};
    cst = 64'hfeedfacecafe0001;
    wr8(`SDT_OFF_XFER, 8'hfe);
    rd8(`SDT_OFF_XFER, 8'h00);
    wr8(`SDT_OFF_XFER, 8'h00);
    cyc(3);
    chk("phase", 96'h0, act);
    chk("coef", 96'h0, {32'h0, cact});
    wr8(`SDT_OFF_XFER, 8'h01);
    rd8(`SDT_OFF_XFER, 8'h01);
    cyc(4);
    rd8(`SDT_OFF_XFER, 8'h00);
    chk("phase", stg, act);
    chk("coef", {32'h0, cst}, {32'h0, cact});
    mode = 1'b0;
    stg = {48'h111122223333, 48'h444455556666};
    cyc(3);
    chk("phase", stg, act);
    // ==========================================================
    // Pin path: walk every field value with the pin held high.
    cm = 2'h3;
    pin = 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      func = f[1:0];
      pw = (f == 0) ? 2'b10 : (f == 1) ? 2'b01 : 2'b00;
      cyc(8);
      chk("power", {94'h0, pw}, {94'h0, pwr});
      chk("chanmode", {94'h0, (f < 2) ? 2'h0 : cm}, {94'h0, cmo});
    end
    func = `SDT_FUNC_POWER_DOWN;
    wr8(`SDT_OFF_LOCAL_PIN, 8'hff);
    rd8(`SDT_OFF_LOCAL_PIN, 8'h80);
    cyc(8);
    chk("power", 96'h0, {94'h0, pwr});
    chk("chanmode", {94'h0, cm}, {94'h0, cmo});
    wr8(`SDT_OFF_LOCAL_PIN, 8'h00);
    cyc(8);
    chk("power", {94'h0, 2'b10}, {94'h0, pwr});
    pin = 1'b0;
    cyc(8);
    chk("power", 96'h0, {94'h0, pwr});
    chk("chanmode", {94'h0, cm}, {94'h0, cmo});
    end_of_test();
  end
endmodule : sdt_shadow_transfer_regs_tb_top
